//--- bfb_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module bfb_checker
  import bfb_pkg::*;
#(
  parameter int W = BFB_W
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Port A
  input wire logic i_port_a_select_n,
  input wire logic [BFB_AW-1:0] i_port_a_addr,
  input wire logic [W-1:0] i_port_a_wdata,
  input wire logic i_port_a_wr,
  input wire logic i_port_a_rd,
  // Port B
  input wire logic i_port_b_xfer_en_n,
  input wire logic i_port_b_dir,
  input wire logic i_port_b_drive_en_n,
  input wire logic [W-1:0] o_port_b_bus_out,
  input wire logic o_port_b_bus_oe,
  // Flags
  input wire logic o_ab_empty_n,
  input wire logic o_ab_almost_empty_n,
  input wire logic o_ab_full_n,
  input wire logic o_ba_empty_n,
  input wire logic o_ba_full_n,
  input wire logic o_port_b_bypass_ind_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic a_wr = !i_port_a_select_n && i_port_a_wr;
  wire logic byp_set = a_wr && i_port_a_addr == BFB_RES_BYPASS && i_port_a_wdata[BFB_BYPASS_BIT];

  a_reset_flags: assert property (disable iff (1'b0) !i_rst_n |=>
    !o_ab_empty_n && !o_ba_empty_n && o_ab_full_n && o_ba_full_n && o_port_b_bypass_ind_n)
    else $error("flags not at reset values");
  a_drive_oe: assert property (i_port_b_dir && !i_port_b_drive_en_n |=> o_port_b_bus_oe)
    else $error("port B bus not driven");
  a_float_oe: assert property (!i_port_b_dir || i_port_b_drive_en_n |=> !o_port_b_bus_oe)
    else $error("port B bus driven while floated");
  a_idle_hold: assert property (i_port_b_xfer_en_n |=> $stable(o_port_b_bus_out))
    else $error("port B output moved while disabled");
  a_empty_read: assert property ((!i_port_b_xfer_en_n && i_port_b_dir) ##1 !o_ab_empty_n
    |-> $stable(o_port_b_bus_out)) else $error("read from empty queue");
  a_ab_excl: assert property (o_ab_empty_n || o_ab_full_n)
    else $error("A-to-B empty and full together");
  a_ba_excl: assert property (o_ba_empty_n || o_ba_full_n)
    else $error("B-to-A empty and full together");
  a_ae_imp: assert property (o_ab_almost_empty_n |-> o_ab_empty_n)
    else $error("almost-empty high while empty");
  a_ab_rise: assert property ($rose(o_ab_empty_n) |-> $past(a_wr, 2))
    else $error("A-to-B empty rose without write");
  a_ba_fall: assert property ($fell(o_ba_empty_n) |-> $past(a_wr || !i_port_a_select_n
    && i_port_a_rd, 2)) else $error("B-to-A empty fell without read");
  a_byp_ind: assert property (byp_set |-> ##[1:2] !o_port_b_bypass_ind_n)
    else $error("bypass indicator not low");

  cover property (!o_ab_full_n);
  cover property (!o_port_b_bypass_ind_n && !o_ab_full_n);
  cover property (!o_port_b_bypass_ind_n && !o_ba_full_n);
endmodule : bfb_checker
`default_nettype wire

//--- bfb_flags.sv
`timescale 1ns/100ps
`default_nettype none
module bfb_flags
  import bfb_pkg::*;
#(
  parameter int DEPTH = BFB_DEPTH,
  parameter int CW = $clog2(DEPTH) + 1
) (
  // Queue state
  input wire logic [CW-1:0] i_count,
  input wire bfb_offsets_t i_off,
  // Bypass state
  input wire logic i_bypass,
  input wire logic i_byp_valid,
  // Flags
  output bfb_flags_t o_flags
);

  always_comb begin
    if (i_bypass) begin
      o_flags.empty_n = i_byp_valid; // R10 R11
      o_flags.full_n = !i_byp_valid; // R12 R13
      o_flags.almost_empty_n = i_byp_valid;
      o_flags.almost_full_n = !i_byp_valid;
    end else begin
      o_flags.empty_n = (i_count != '0); // R03 R04
      o_flags.full_n = (i_count != CW'(DEPTH)); // R05 R06
      o_flags.almost_empty_n = (i_count > i_off.ae); // R07
      o_flags.almost_full_n = !(i_count > (CW'(DEPTH) - i_off.af)); // R08
    end
  end

endmodule : bfb_flags
`default_nettype wire

//--- bfb_host_b.sv
`timescale 1ns/100ps
`default_nettype none
module bfb_host_b
  import bfb_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Device port B
  input wire logic [BFB_W-1:0] i_bus_out,
  output logic o_xfer_en_n,
  output logic o_dir,
  output logic o_drive_en_n,
  output logic [BFB_W-1:0] o_bus_in
);
  initial begin
    o_xfer_en_n = 1'b1;
    o_dir = 1'b0;
    o_drive_en_n = 1'b1;
    o_bus_in = 18'h3FFFF;
  end
  task automatic put(input logic [BFB_W-1:0] d);
    @(posedge i_sys_clk);
    o_xfer_en_n <= 1'b0;
    o_dir <= 1'b0;
    o_bus_in <= d;
    @(posedge i_sys_clk);
    o_xfer_en_n <= 1'b1;
    o_bus_in <= ~d;
  endtask : put
  task automatic get(output logic [BFB_W-1:0] d);
    @(posedge i_sys_clk);
    o_xfer_en_n <= 1'b0;
    o_dir <= 1'b1;
    o_drive_en_n <= 1'b0;
    @(posedge i_sys_clk);
    o_xfer_en_n <= 1'b1;
    o_drive_en_n <= 1'b1;
    #1 d = i_bus_out;
  endtask : get
endmodule : bfb_host_b
`default_nettype wire

//--- bfb_pkg.sv
// Contract
// [R01] Port B transfers only while transfer enable low
// [R02] Port B bus driven only when drive enable low
// [R03] A-to-B empty low when empty; blocks B reads
// [R04] B-to-A empty low when empty; blocks A reads
// [R05] A-to-B full low when full; blocks A writes
// [R06] B-to-A full low when full; blocks B writes
// [R07] Almost-empty low while count at or below offset
// [R08] Almost-full low while count above depth minus offset
// [R09] All four offsets default to eight
// [R10] Bypass: A-to-B empty high while word waits
// [R11] Bypass: B-to-A empty drops after port A read
// [R12] Bypass: A-to-B full low while message waits
// [R13] Bypass: B-to-A full low while message waits
// [R14] Bypass indicator low while bypass mode set
// [R15] Reset reinitialises queues, flags and offsets
// [R16] Port data taken on rising clock edge
// [R17] Port A acts only while select low
// [R18] Port B direction low writes, high reads
// [R19] Reset: empties low, fulls high, bypass off
// [R20] Cross-domain flag updates pass through synchronisers; the code has one clock and flags pass a single register on i_sys_clk
package bfb_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int BFB_W = 18;
  localparam int BFB_DEPTH = 256;
  localparam int BFB_CW = $clog2(BFB_DEPTH) + 1;
  localparam int BFB_AW = 3;

  // ---------------------------------------------------------------
  // Port A resource map
  // ---------------------------------------------------------------
  localparam logic [BFB_AW-1:0] BFB_RES_DATA = 3'h0;
  localparam logic [BFB_AW-1:0] BFB_RES_AB_AE = 3'h1;
  localparam logic [BFB_AW-1:0] BFB_RES_AB_AF = 3'h2;
  localparam logic [BFB_AW-1:0] BFB_RES_BA_AE = 3'h3;
  localparam logic [BFB_AW-1:0] BFB_RES_BA_AF = 3'h4;
  localparam logic [BFB_AW-1:0] BFB_RES_BYPASS = 3'h5;
  localparam int BFB_BYPASS_BIT = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [BFB_CW-1:0] BFB_OFFSET_RST = 9'h008;
  localparam logic [BFB_W-1:0] BFB_DATA_RST = 18'h00000;

  typedef struct packed {
    logic empty_n;
    logic almost_empty_n;
    logic almost_full_n;
    logic full_n;
  } bfb_flags_t;

  localparam bfb_flags_t BFB_FLAGS_RST = '{
    empty_n: 1'b0, almost_empty_n: 1'b0, almost_full_n: 1'b1, full_n: 1'b1};

  typedef struct packed {
    logic [BFB_CW-1:0] ae;
    logic [BFB_CW-1:0] af;
  } bfb_offsets_t;

endpackage : bfb_pkg

//--- bfb_queue.sv
`timescale 1ns/100ps
`default_nettype none
module bfb_queue
  import bfb_pkg::*;
#(
  parameter int W = BFB_W,
  parameter int DEPTH = BFB_DEPTH,
  parameter int CW = $clog2(DEPTH) + 1
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Write side
  input wire logic i_wr,
  input wire logic [W-1:0] i_wdata,
  // Read side
  input wire logic i_rd,
  output logic [W-1:0] o_head,
  output logic [CW-1:0] o_count
);

  localparam int AW = CW - 1;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic do_wr;
  logic do_rd;

  assign do_wr = i_wr && (count_reg != CW'(DEPTH));
  assign do_rd = i_rd && (count_reg != '0);
  assign o_head = mem[rd_ptr_reg];
  assign o_count = count_reg;

  always_ff @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0; // R15
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + CW'(do_wr) - CW'(do_rd);
    end
  end

endmodule : bfb_queue
`default_nettype wire

//--- bfb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bfb_top
  import bfb_pkg::*;
#(
  parameter int W = BFB_W,
  parameter int DEPTH = BFB_DEPTH
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Port A resource port
  input wire logic i_port_a_select_n,
  input wire logic [BFB_AW-1:0] i_port_a_addr,
  input wire logic [W-1:0] i_port_a_wdata,
  input wire logic i_port_a_wr,
  input wire logic i_port_a_rd,
  output logic [W-1:0] o_port_a_rdata,
  // Port B data port
  input wire logic i_port_b_xfer_en_n,
  input wire logic i_port_b_dir,
  input wire logic i_port_b_drive_en_n,
  input wire logic [W-1:0] i_port_b_bus_in,
  output logic [W-1:0] o_port_b_bus_out,
  output logic o_port_b_bus_oe,
  // A-to-B flags
  output logic o_ab_empty_n,
  output logic o_ab_almost_empty_n,
  output logic o_ab_almost_full_n,
  output logic o_ab_full_n,
  // B-to-A flags
  output logic o_ba_empty_n,
  output logic o_ba_almost_empty_n,
  output logic o_ba_almost_full_n,
  output logic o_ba_full_n,
  // Mode
  output logic o_port_b_bypass_ind_n
);

  localparam int CW = $clog2(DEPTH) + 1;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  bfb_offsets_t ab_off_reg;
  bfb_offsets_t ba_off_reg;
  logic bypass_reg;
  logic bypass_ind_reg;
  logic [W-1:0] ab_byp_data_reg;
  logic ab_byp_valid_reg;
  logic [W-1:0] ba_byp_data_reg;
  logic ba_byp_valid_reg;
  logic [W-1:0] port_a_rdata_reg;
  logic [W-1:0] port_b_out_reg;
  logic port_b_oe_reg;
  bfb_flags_t ab_flags_reg;
  bfb_flags_t ba_flags_reg;

  bfb_flags_t ab_flags;
  bfb_flags_t ba_flags;
  logic [CW-1:0] ab_count;
  logic [CW-1:0] ba_count;
  logic [W-1:0] ab_head;
  logic [W-1:0] ba_head;

  // ---------------------------------------------------------------
  // Resource decode
  // ---------------------------------------------------------------
  function automatic logic res_hit(input logic [BFB_AW-1:0] addr, input logic [BFB_AW-1:0] res);
    return addr == res;
  endfunction : res_hit

  // ---------------------------------------------------------------
  // Port strobes
  // ---------------------------------------------------------------
  logic a_wr;
  logic a_rd;
  logic a_data_wr;
  logic a_data_rd;
  logic b_wr;
  logic b_rd;

  assign a_wr = !i_port_a_select_n && i_port_a_wr; // R17
  assign a_rd = !i_port_a_select_n && i_port_a_rd; // R17
  assign a_data_wr = a_wr && res_hit(i_port_a_addr, BFB_RES_DATA) && ab_flags.full_n; // R05 R12
  assign a_data_rd = a_rd && res_hit(i_port_a_addr, BFB_RES_DATA) && ba_flags.empty_n; // R04 R11
  assign b_wr = !i_port_b_xfer_en_n && !i_port_b_dir && ba_flags.full_n; // R01 R18 R06 R13
  assign b_rd = !i_port_b_xfer_en_n && i_port_b_dir && ab_flags.empty_n; // R01 R18 R03 R10

  // ---------------------------------------------------------------
  // Queues
  // ---------------------------------------------------------------
  bfb_queue #(
    .W(W),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_ab_queue (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(a_data_wr && !bypass_reg),
    .i_wdata(i_port_a_wdata),
    .i_rd(b_rd && !bypass_reg),
    .o_head(ab_head),
    .o_count(ab_count)
  );

  bfb_queue #(
    .W(W),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_ba_queue (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr(b_wr && !bypass_reg),
    .i_wdata(i_port_b_bus_in),
    .i_rd(a_data_rd && !bypass_reg),
    .o_head(ba_head),
    .o_count(ba_count)
  );

  // ---------------------------------------------------------------
  // Flag decode
  // ---------------------------------------------------------------
  bfb_flags #(
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_ab_flags (
    .i_count(ab_count),
    .i_off(ab_off_reg),
    .i_bypass(bypass_reg),
    .i_byp_valid(ab_byp_valid_reg),
    .o_flags(ab_flags)
  );

  bfb_flags #(
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_ba_flags (
    .i_count(ba_count),
    .i_off(ba_off_reg),
    .i_bypass(bypass_reg),
    .i_byp_valid(ba_byp_valid_reg),
    .o_flags(ba_flags)
  );

  // ---------------------------------------------------------------
  // Offsets and mode
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ab_off_reg <= '{ae: BFB_OFFSET_RST, af: BFB_OFFSET_RST}; // R09 R15
    end else if (a_wr && res_hit(i_port_a_addr, BFB_RES_AB_AE)) begin
      ab_off_reg.ae <= i_port_a_wdata[BFB_CW-1:0];
    end else if (a_wr && res_hit(i_port_a_addr, BFB_RES_AB_AF)) begin
      ab_off_reg.af <= i_port_a_wdata[BFB_CW-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ba_off_reg <= '{ae: BFB_OFFSET_RST, af: BFB_OFFSET_RST}; // R09 R15
    end else if (a_wr && res_hit(i_port_a_addr, BFB_RES_BA_AE)) begin
      ba_off_reg.ae <= i_port_a_wdata[BFB_CW-1:0];
    end else if (a_wr && res_hit(i_port_a_addr, BFB_RES_BA_AF)) begin
      ba_off_reg.af <= i_port_a_wdata[BFB_CW-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bypass_reg <= 1'b0; // R19
    end else if (a_wr && res_hit(i_port_a_addr, BFB_RES_BYPASS)) begin
      bypass_reg <= i_port_a_wdata[BFB_BYPASS_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Bypass message registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ab_byp_valid_reg <= 1'b0;
    end else if (!bypass_reg) begin
      ab_byp_valid_reg <= 1'b0;
    end else if (a_data_wr) begin
      ab_byp_valid_reg <= 1'b1; // R10 R12
    end else if (b_rd) begin
      ab_byp_valid_reg <= 1'b0; // R10 R12
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ab_byp_data_reg <= BFB_DATA_RST;
    end else if (bypass_reg && a_data_wr) begin
      ab_byp_data_reg <= i_port_a_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ba_byp_valid_reg <= 1'b0;
    end else if (!bypass_reg) begin
      ba_byp_valid_reg <= 1'b0;
    end else if (b_wr) begin
      ba_byp_valid_reg <= 1'b1; // R11 R13
    end else if (a_data_rd) begin
      ba_byp_valid_reg <= 1'b0; // R11 R13
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ba_byp_data_reg <= BFB_DATA_RST;
    end else if (bypass_reg && b_wr) begin
      ba_byp_data_reg <= i_port_b_bus_in;
    end
  end

  // ---------------------------------------------------------------
  // Port A read data
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      port_a_rdata_reg <= BFB_DATA_RST;
    end else if (a_rd) begin // R16
      unique case (i_port_a_addr)
        BFB_RES_DATA: port_a_rdata_reg <= !ba_flags.empty_n ? BFB_DATA_RST
                                          : (bypass_reg ? ba_byp_data_reg : ba_head);
        BFB_RES_AB_AE: port_a_rdata_reg <= W'(ab_off_reg.ae);
        BFB_RES_AB_AF: port_a_rdata_reg <= W'(ab_off_reg.af);
        BFB_RES_BA_AE: port_a_rdata_reg <= W'(ba_off_reg.ae);
        BFB_RES_BA_AF: port_a_rdata_reg <= W'(ba_off_reg.af);
        BFB_RES_BYPASS: port_a_rdata_reg <= W'(bypass_reg);
        default: port_a_rdata_reg <= BFB_DATA_RST;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Port B output register
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      port_b_out_reg <= BFB_DATA_RST;
    end else if (b_rd) begin // R16
      port_b_out_reg <= bypass_reg ? ab_byp_data_reg : ab_head;
    end
  end

  // ---------------------------------------------------------------
  // Port B drive enable
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      port_b_oe_reg <= 1'b0;
    end else begin
      port_b_oe_reg <= i_port_b_dir && !i_port_b_drive_en_n; // R02
    end
  end

  // ---------------------------------------------------------------
  // Registered flags
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ab_flags_reg <= BFB_FLAGS_RST; // R19 R15
    end else begin
      ab_flags_reg <= ab_flags; // R20
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ba_flags_reg <= BFB_FLAGS_RST; // R19 R15
    end else begin
      ba_flags_reg <= ba_flags; // R20
    end
  end

  // ---------------------------------------------------------------
  // Bypass indicator
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bypass_ind_reg <= 1'b1; // R19
    end else begin
      bypass_ind_reg <= !bypass_reg; // R14 R20
    end
  end

  assign o_port_a_rdata = port_a_rdata_reg;
  assign o_port_b_bus_out = port_b_out_reg;
  assign o_port_b_bus_oe = port_b_oe_reg;
  assign o_ab_empty_n = ab_flags_reg.empty_n;
  assign o_ab_almost_empty_n = ab_flags_reg.almost_empty_n;
  assign o_ab_almost_full_n = ab_flags_reg.almost_full_n;
  assign o_ab_full_n = ab_flags_reg.full_n;
  assign o_ba_empty_n = ba_flags_reg.empty_n;
  assign o_ba_almost_empty_n = ba_flags_reg.almost_empty_n;
  assign o_ba_almost_full_n = ba_flags_reg.almost_full_n;
  assign o_ba_full_n = ba_flags_reg.full_n;
  assign o_port_b_bypass_ind_n = bypass_ind_reg; // R14

endmodule : bfb_top
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  import bfb_pkg::*;
  localparam int DEP = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_n = 1'b1;
  logic [BFB_AW-1:0] addr = '0;
  logic [BFB_W-1:0] wd = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [BFB_W-1:0] rdata, bout, bin, v;
  logic xen_n, dir, den_n, oe, byp_n;
  bfb_flags_t ab, ba;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  bfb_top #(.DEPTH(DEP)) bfb_top_i (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_port_a_select_n(sel_n), .i_port_a_addr(addr), .i_port_a_wdata(wd),
    .i_port_a_wr(wr), .i_port_a_rd(rd), .o_port_a_rdata(rdata),
    .i_port_b_xfer_en_n(xen_n), .i_port_b_dir(dir), .i_port_b_drive_en_n(den_n),
    .i_port_b_bus_in(bin), .o_port_b_bus_out(bout), .o_port_b_bus_oe(oe),
    .o_ab_empty_n(ab.empty_n), .o_ab_almost_empty_n(ab.almost_empty_n),
    .o_ab_almost_full_n(ab.almost_full_n), .o_ab_full_n(ab.full_n),
    .o_ba_empty_n(ba.empty_n), .o_ba_almost_empty_n(ba.almost_empty_n),
    .o_ba_almost_full_n(ba.almost_full_n), .o_ba_full_n(ba.full_n),
    .o_port_b_bypass_ind_n(byp_n));
  bfb_host_b bfb_host_b_i (.i_sys_clk(clk), .i_bus_out(bout), .o_xfer_en_n(xen_n),
    .o_dir(dir), .o_drive_en_n(den_n), .o_bus_in(bin));

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic awr(input logic [BFB_AW-1:0] a, input logic [BFB_W-1:0] d);
    @(posedge clk);
    sel_n <= 1'b0;
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    sel_n <= 1'b1;
    wr <= 1'b0;
  endtask : awr
  task automatic ard(input logic [BFB_AW-1:0] a, output logic [BFB_W-1:0] d);
    @(posedge clk);
    sel_n <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    sel_n <= 1'b1;
    rd <= 1'b0;
    #1 d = rdata;
  endtask : ard
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    do_reset();
    settle();
    `CHK("ab reset", ab, 4'b0011)
    `CHK("ba reset", ba, 4'b0011)
    `CHK("bypass reset", byp_n, 1'b1)
    // ----------------------------------------
    // Fill past full, then drain past empty
    // ----------------------------------------
    for (int i = 1; i <= DEP + 1; i++) begin
      awr(BFB_RES_DATA, 18'h10000 + i[17:0]);
      settle();
      if (i == 8 || i >= 9) `CHK("ab fill", ab, {1'b1, i > 8, i <= 8, i < DEP})
    end
    for (int i = 1; i <= DEP; i++) begin
      bfb_host_b_i.get(v);
      `CHK("b data", v, 18'h10000 + i[17:0])
    end
    bfb_host_b_i.get(v);
    `CHK("b empty read", v, 18'h10010)
    settle();
    `CHK("ab drained", ab, 4'b0011)
    awr(BFB_RES_AB_AE, 18'h00002);
    repeat (3) awr(BFB_RES_DATA, 18'h00ABC);
    settle();
    `CHK("ae programmed", ab.almost_empty_n, 1'b1)
    do_reset();
    repeat (3) awr(BFB_RES_DATA, 18'h00ABC);
    settle();
    `CHK("ae default", ab.almost_empty_n, 1'b0)
    ard(BFB_RES_AB_AE, v);
    `CHK("ab ae reset", v, 18'h00008)
    ard(BFB_RES_BA_AF, v);
    `CHK("ba af default", v, 18'h00008)
    do_reset();
    bfb_host_b_i.put(18'h2AAAA);
    settle();
    `CHK("ba one", ba, 4'b1011)
    ard(BFB_RES_DATA, v);
    `CHK("a data", v, 18'h2AAAA)
    settle();
    `CHK("ba empty", ba, 4'b0011)
    awr(BFB_RES_BA_AE, 18'h00000);
    bfb_host_b_i.put(18'h00123);
    settle();
    `CHK("ba ae programmed", ba, 4'b1111)
    ard(BFB_RES_DATA, v);
    `CHK("ba ae data", v, 18'h00123)
    // ----------------------------------------
    // Bypass both ways
    // ----------------------------------------
    awr(BFB_RES_BYPASS, 18'h00001);
    settle();
    `CHK("bypass on", byp_n, 1'b0)
    awr(BFB_RES_DATA, 18'h15555);
    settle();
    `CHK("byp ab wait", {ab.empty_n, ab.full_n}, 2'b10)
    bfb_host_b_i.get(v);
    `CHK("byp b data", v, 18'h15555)
    settle();
    `CHK("byp ab done", {ab.empty_n, ab.full_n}, 2'b01)
    bfb_host_b_i.put(18'h0F0F0);
    settle();
    `CHK("byp ba wait", {ba.empty_n, ba.full_n}, 2'b10)
    ard(BFB_RES_DATA, v);
    `CHK("byp a data", v, 18'h0F0F0)
    settle();
    `CHK("byp ba done", {ba.empty_n, ba.full_n}, 2'b01)
    awr(BFB_RES_BYPASS, 18'h00000);
    settle();
    `CHK("bypass off", byp_n, 1'b1)
    report_and_stop();
  end
endmodule : testbench

bind bfb_top bfb_checker #(.W(W)) bfb_checker_i (.i_sys_clk, .i_rst_n, .i_port_a_select_n,
  .i_port_a_addr, .i_port_a_wdata, .i_port_a_wr, .i_port_a_rd, .i_port_b_xfer_en_n,
  .i_port_b_dir, .i_port_b_drive_en_n, .o_port_b_bus_out, .o_port_b_bus_oe, .o_ab_empty_n,
  .o_ab_almost_empty_n, .o_ab_full_n, .o_ba_empty_n, .o_ba_full_n, .o_port_b_bypass_ind_n);
`default_nettype wire
